/* hdl/apc_power_seq.sv */
`timescale 1ns/1ps
// What this block does
// - mode 00: power on trigger, then wake
// - mode 01: reference kept on when chosen as reference, still wake
// - mode 10: converter and reference kept on
// - kept-on mode skips the wake-up wait
// - mode 11 behaves like mode 10
// - only power-on/brown-out resets register
module apc_power_seq (
  // clock and resets
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        por_bor_rst_in,
  // ahb-lite
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // converter side
  input  wire logic        conv_trigger_in,
  input  wire logic        active_or_halt_in,
  input  wire logic        ref_selected_in,
  output logic             adc_power_out,
  output logic             ref_buf_power_out,
  output logic             conv_start_out
);
  apc_ctrl_if ctrl_if ();

  apc_reg_slave u_slave (
    .sys_clk_in     (sys_clk_in),
    .srst_in        (srst_in),
    .por_bor_rst_in (por_bor_rst_in),
    .hsel_in        (hsel_in),
    .haddr_in       (haddr_in),
    .htrans_in      (htrans_in),
    .hwrite_in      (hwrite_in),
    .hsize_in       (hsize_in),
    .hwdata_in      (hwdata_in),
    .hready_in      (hready_in),
    .hrdata_out     (hrdata_out),
    .hreadyout_out  (hreadyout_out),
    .hresp_out      (hresp_out),
    .ctrl           (ctrl_if.source)
  );

  ////////////////////////////////////////////////////////////////
  // sequencer state, one struct
  typedef struct packed {
    apc_pkg::apc_state_t              st;
    logic [apc_pkg::WAKE_CNT_W-1:0]   cnt;
    logic                             adc_pwr;
    logic                             ref_pwr;
    logic                             start;
  } apc_seq_t;
  apc_seq_t q, d;
  apc_pkg::apc_mode_t mode;

  // decode kept-on: codes 10 and 11 alike
  function automatic logic kept_on(input apc_pkg::apc_mode_t m);
    return m[1];
  endfunction

  assign mode = apc_pkg::apc_mode_t'(
    ctrl_if.power_ctrl[apc_pkg::MODE_MSB:apc_pkg::MODE_LSB]);

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.adc_pwr = kept_on(mode) && active_or_halt_in;
    d.ref_pwr = active_or_halt_in && (kept_on(mode) ||
                (mode == apc_pkg::APC_MODE_REF_ON && ref_selected_in));
    unique case (q.st)
      apc_pkg::APC_ST_IDLE: begin
        if (conv_trigger_in) begin
          if (kept_on(mode)) begin
            d.start = 1'b1;
          end else begin
            d.st  = apc_pkg::APC_ST_WAKE;
            d.cnt = apc_pkg::WAKE_CNT_W'(apc_pkg::WAKE_CYCLES - 1);
          end
        end
      end
      apc_pkg::APC_ST_WAKE: begin
        // converter powered while waking
        d.adc_pwr = 1'b1;
        d.ref_pwr = 1'b1;
        if (q.cnt == '0) begin
          d.st = apc_pkg::APC_ST_START;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      apc_pkg::APC_ST_START: begin
        // issue start, keep power for the conversion
        d.adc_pwr = 1'b1;
        d.ref_pwr = 1'b1;
        d.start   = 1'b1;
        d.st      = apc_pkg::APC_ST_IDLE;
      end
      default: begin
        d.st = apc_pkg::APC_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // sequencer flops, ordinary system reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || por_bor_rst_in) begin
      q <= '{apc_pkg::APC_ST_IDLE, '0, 1'b0, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  assign adc_power_out     = q.adc_pwr;
  assign ref_buf_power_out = q.ref_pwr;
  assign conv_start_out    = q.start;

  ////////////////////////////////////////////////////////////////
  // checks; one clock, each quiet while a reset is high, except
  // the register check, which must hold through a system reset
  // waiting-mode (00 or 01) trigger taken in idle
  sequence s_wait_trig;
    q.st == apc_pkg::APC_ST_IDLE && conv_trigger_in && !kept_on(mode);
  endsequence

  // kept-on trigger taken in idle
  sequence s_fast_trig;
    q.st == apc_pkg::APC_ST_IDLE && conv_trigger_in && kept_on(mode);
  endsequence

  // wake counter still running
  sequence s_waking;
    q.st == apc_pkg::APC_ST_WAKE && q.cnt != '0;
  endsequence

  // last cycle of the wake wait
  sequence s_wake_done;
    q.st == apc_pkg::APC_ST_WAKE && q.cnt == '0;
  endsequence

  // start state, then the start pulse a cycle later
  sequence s_start_pulse;
    q.st == apc_pkg::APC_ST_START ##1 conv_start_out;
  endsequence

  // no start during the first stretch of the wait
  a_auto_wake_wait: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_wait_trig |=> !conv_start_out [*8])
    else $error("start came before wake time");

  // the wait always loads the full wake count
  a_wake_load: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_wait_trig |=> q.st == apc_pkg::APC_ST_WAKE &&
      q.cnt == apc_pkg::WAKE_CNT_W'(apc_pkg::WAKE_CYCLES - 1))
    else $error("wake count not loaded");

  // one step down per cycle, so the wait cannot be cut short
  a_wake_count: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_waking |=> q.st == apc_pkg::APC_ST_WAKE &&
      q.cnt == $past(q.cnt) - 1'b1)
    else $error("wake count skipped");

  // converter and buffer powered from the second cycle of the wait on
  a_wake_power: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_waking |=> adc_power_out && ref_buf_power_out)
    else $error("converter unpowered while waking");

  // end of the wait leads to the start pulse
  a_wake_to_start: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_wake_done |=> s_start_pulse)
    else $error("wake end gave no start");

  // kept-on trigger starts on the very next cycle
  a_kept_on_start: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    s_fast_trig |=> conv_start_out)
    else $error("kept-on start delayed");

  // kept-on codes power both parts while active or halted
  a_kept_on_power: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    (kept_on(mode) && active_or_halt_in) |=> adc_power_out
      && ref_buf_power_out)
    else $error("kept-on power missing");

  // reference buffer held when chosen as positive reference
  a_ref_held: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    (mode == apc_pkg::APC_MODE_REF_ON && ref_selected_in
     && active_or_halt_in) |=> ref_buf_power_out)
    else $error("reference buffer not held");

  // reserved code acts as the kept-on code
  a_rsvd_as_on: assert property (@(posedge sys_clk_in)
    disable iff (srst_in || por_bor_rst_in)
    (mode == apc_pkg::APC_MODE_RSVD && active_or_halt_in)
    |=> adc_power_out)
    else $error("reserved code not kept on");

  // no disable here: the point is to watch through system reset
  a_reg_survives: assert property (@(posedge sys_clk_in)
    (srst_in && !por_bor_rst_in) |=>
      ctrl_if.power_ctrl == $past(ctrl_if.power_ctrl))
    else $error("system reset touched register");
endmodule

/* hdl/apc_pkg.sv */
package apc_pkg;
  // register index, not word aligned: byte address is four times it
  localparam logic [11:0] REG_IDX_POWER_CTRL = 12'hF81;
  localparam logic [13:0] ADDR_POWER_CTRL    = 14'(REG_IDX_POWER_CTRL) << 2;
  // field positions
  localparam int          MODE_LSB   = 2;
  localparam int          MODE_MSB   = 3;
  // reset value of the register
  localparam logic [7:0]  POWER_CTRL_RESET = 8'h00;
  // converter wake-up time, in ns, and derived cycle count at 200 MHz
  localparam int          WAKE_TIME_NS    = 1000;
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          WAKE_CYCLES     =
    (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAKE_CNT_W      = 12;
  // power mode encodings
  typedef enum logic [1:0] {
    APC_MODE_AUTO    = 2'b00,
    APC_MODE_REF_ON  = 2'b01,
    APC_MODE_ALL_ON  = 2'b10,
    APC_MODE_RSVD    = 2'b11
  } apc_mode_t;
  // sequencer states
  typedef enum logic [1:0] {
    APC_ST_IDLE  = 2'b00,
    APC_ST_WAKE  = 2'b01,
    APC_ST_START = 2'b10
  } apc_state_t;
endpackage

/* hdl/apc_ctrl_if.sv */
`timescale 1ns/1ps
// register value handed from the bus slave to the sequencer
interface apc_ctrl_if;
  logic [7:0] power_ctrl;   // stored register value
  modport source (output power_ctrl);
  modport sink   (input  power_ctrl);
endinterface

/* hdl/apc_reg_slave.sv */
`timescale 1ns/1ps
// ahb-lite slave holding the one power control register
module apc_reg_slave (
  // clock and resets
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        por_bor_rst_in,
  // ahb-lite
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // register value
  apc_ctrl_if.source       ctrl
);
  typedef struct packed {
    logic       wr_pend;   // write in data phase
    logic       hit;       // address phase hit our word
    logic [7:0] reg_val;   // the register
    logic [31:0] rdata;    // registered read data
  } apc_slv_t;
  apc_slv_t s_q, s_d;
  logic unused_srst;
  assign unused_srst = srst_in;

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    // commit pending write; all eight bits stored, reserved included
    if (s_q.wr_pend && s_q.hit) begin
      s_d.reg_val = hwdata_in[7:0];
    end
    s_d.wr_pend = 1'b0;
    if (hsel_in && hready_in && htrans_in[1]) begin
      s_d.hit     = (haddr_in[13:0] == apc_pkg::ADDR_POWER_CTRL)
                    && (haddr_in[31:14] == 18'h00000);
      s_d.wr_pend = hwrite_in;
      // unmapped reads return zero
      s_d.rdata   = (!hwrite_in && s_d.hit) ?
                    {24'h000000, s_d.reg_val} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // only por/brown-out clears
  always_ff @(posedge sys_clk_in) begin
    if (por_bor_rst_in) begin
      s_q <= '{1'b0, 1'b0, apc_pkg::POWER_CTRL_RESET, 32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_out      = s_q.rdata;
  assign hreadyout_out   = 1'b1;
  assign hresp_out       = 1'b0;
  assign ctrl.power_ctrl = s_q.reg_val;
endmodule

/* tb/tb_adc_power_enable_control.sv */
`timescale 1ns/1ps
module tb_adc_power_enable_control;
  // clock, resets, bus and converter side
  logic        clk;
  logic        srst;
  logic        por;
  logic        hwrite;
  logic        trig;
  logic        act;
  logic        rsel;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hresp;
  logic        adc_pw;
  logic        ref_pw;
  logic        start;
  int          failures;
  int          checks;
  int          n;
  localparam logic [31:0] RA = 32'(apc_pkg::ADDR_POWER_CTRL);
  ////////////////////////////////////////////////////////////////////////////
  apc_power_seq i_dut (
    .sys_clk_in(clk), .srst_in(srst), .por_bor_rst_in(por),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .conv_trigger_in(trig), .active_or_halt_in(act),
    .ref_selected_in(rsel), .adc_power_out(adc_pw),
    .ref_buf_power_out(ref_pw), .conv_start_out(start)
  );
  // free-running 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task test_done();
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait for hready sampled high
  task wt();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask
  // one single ahb-lite transfer, read data kept in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  // trigger one conversion, count cycles from trigger edge to start
  task conv(input int exp_n);
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    n = 0;
    // a kept-on start already stands here, so look before waiting
    while (start !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) chk(32'(adc_pw), 32'h1);
    end
    chk(32'(n), 32'(exp_n));
    if (start !== 1'b1) begin
      test_done();
    end
    // start is a one-cycle pulse
    @(posedge clk);
    #1;
    chk(32'(start), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks   = 0;
    srst     = 1'b1;
    por      = 1'b1;
    hwrite   = 1'b0;
    htrans   = 2'h0;
    haddr    = 32'h0;
    hwdata   = 32'h0;
    trig     = 1'b0;
    act      = 1'b0;
    rsel     = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    por  <= 1'b0;
    bus(1'b0, RA, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    // unmapped word ignores writes and reads zero
    bus(1'b1, RA + 32'h4, 32'hFF);
    bus(1'b0, RA + 32'h4, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, RA, 32'h0);
    chk(rd, 32'h0);
    act  <= 1'b1;
    rsel <= 1'b1;
    // every mode, reserved bits kept zero
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, RA, 32'(m << 2));
      bus(1'b0, RA, 32'h0);
      chk(rd, 32'(m << 2));
      repeat (3) @(posedge clk);
      #1;
      chk(32'(adc_pw), 32'(m > 1));
      chk(32'(ref_pw), 32'(m > 0));
      conv(m > 1 ? 0 : apc_pkg::WAKE_CYCLES + 1);
    end
    // system reset leaves the register
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, RA, 32'h0);
    chk(rd, 32'hC);
    // kept-on power only while active or halted
    @(posedge clk);
    act <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(adc_pw), 32'h0);
    // buffer stays off when not chosen as reference
    @(posedge clk);
    act  <= 1'b1;
    rsel <= 1'b0;
    bus(1'b1, RA, 32'h4);
    repeat (3) @(posedge clk);
    #1;
    chk(32'(ref_pw), 32'h0);
    chk(32'(adc_pw), 32'h0);
    // power-on reset clears it
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    bus(1'b0, RA, 32'h0);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
